/* pkg/bwfa_defines.vh */
// constants for the boot watchdog and fault alert block
// assumes inclusion by bare name from the design files
`ifndef BWFA_DEFINES_VH
`define BWFA_DEFINES_VH

// clock and timeout
`define BWFA_CLK_MHZ        125
`define BWFA_TIMEOUT_MIN    26
// cycles = minutes * 60 * 1e6 * MHz, rounded down as a longest time
`define BWFA_TIMEOUT_CYC    (38'd26 * 38'd60 * 38'd1000000 * 38'd125)
`define BWFA_CNT_W          38

// processor count and index width
`define BWFA_NUM_CPU        4
`define BWFA_CPU_W          2

// counts of chassis inputs
`define BWFA_NUM_FAN        4
`define BWFA_NUM_PSU        3
`define BWFA_NUM_DOOR       2

// watchdog states
`define BWFA_ST_SELFTEST    2'h0
`define BWFA_ST_COUNT       2'h1
`define BWFA_ST_DONE        2'h2
`define BWFA_ST_LASTBAD     2'h3

`endif

/* rtl/bwfa_status_bits.v */
// sticky status store: one bit per entry, set by hardware, cleared by reset only
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none

module bwfa_status_bits #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_b,
  // set requests
  input  wire [WIDTH-1:0] set_i,
  // held bits
  output wire [WIDTH-1:0] bits_o
);

  reg [WIDTH-1:0] bits_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          bits_q[g] <= 1'b0;
        end else if (set_i[g]) begin
          bits_q[g] <= 1'b1;
        end
      end
    end
  endgenerate

  assign bits_o = bits_q;

endmodule

`default_nettype wire

/* rtl/bwfa_top.v */
// boot watchdog with processor hand-over, and chassis fault alert gathering
// assumes synchronous inputs, one 125 MHz clock, asynchronous active-low reset
`timescale 1ns/1ns
`include "bwfa_defines.vh"
`default_nettype none

// Notes on behaviour
// - the four fan failure lines are ORed into one fan alert
// - either chassis switch open raises the security breach alert
// - supply fault lamp lights when any installed supply reports a fault
// - a presence bit is kept beside each supply fault bit
// - watchdog loads once the acting processor passes self test and counts down without software
// - timeout fixed near 26 minutes; no software control of it
// - reaching zero before disable marks the acting processor faulty
// - a processor failing self test is faulty and skipped
// - a faulty acting processor is removed; role moves to the next
// - when all are faulty, boot with the processor marked faulty last
module bwfa_top #(
  parameter        NUM_CPU     = `BWFA_NUM_CPU,
  parameter        NUM_FAN     = `BWFA_NUM_FAN,
  parameter        NUM_PSU     = `BWFA_NUM_PSU,
  parameter [37:0] TIMEOUT_CYC = `BWFA_TIMEOUT_CYC
) (
  // clock and reset
  input  wire                    clk,
  input  wire                    rst_b,
  // chassis inputs
  input  wire [NUM_FAN-1:0]      fan_fail,
  input  wire                    cover_open,
  input  wire                    bay_door_open,
  input  wire [NUM_PSU-1:0]      psu_fault,
  input  wire [NUM_PSU-1:0]      psu_present,
  // processor side
  input  wire [NUM_CPU-1:0]      cpu_installed,
  input  wire [NUM_CPU-1:0]      processor_self_test_fail,
  input  wire                    wdog_disable,
  // alerts
  output reg                     fan_alert,
  output reg                     breach_alert,
  output reg                     psu_fault_led,
  output wire [NUM_PSU-1:0]      psu_fault_status,
  output wire [NUM_PSU-1:0]      psu_present_status,
  output wire                    fan_alert_status,
  output wire                    breach_alert_status,
  // boot role
  output reg  [`BWFA_CPU_W-1:0]  boot_processor_role,
  output reg  [NUM_CPU-1:0]      cpu_enable,
  output wire [NUM_CPU-1:0]      cpu_fault_status,
  output reg                     fault_resilient_boot_done,
  output reg                     all_cpu_faulty,
  output reg  [`BWFA_CNT_W-1:0]  wdog_count
);

  localparam ST_SELFTEST = `BWFA_ST_SELFTEST;
  localparam ST_COUNT    = `BWFA_ST_COUNT;
  localparam ST_DONE     = `BWFA_ST_DONE;
  localparam ST_LASTBAD  = `BWFA_ST_LASTBAD;
  localparam SW          = 2 * NUM_PSU + NUM_CPU + 2;

  reg  [1:0]             state_q;
  reg  [1:0]             state_d;
  reg  [`BWFA_CNT_W-1:0] cnt_q;
  reg  [`BWFA_CNT_W-1:0] cnt_d;
  reg  [`BWFA_CPU_W-1:0] cur_q;
  reg  [`BWFA_CPU_W-1:0] cur_d;
  reg  [`BWFA_CPU_W-1:0] last_q;
  reg  [`BWFA_CPU_W-1:0] last_d;
  reg  [NUM_CPU-1:0]     bad_q;
  reg  [NUM_CPU-1:0]     bad_d;
  reg  [`BWFA_CPU_W-1:0] next_idx;
  reg                    next_ok;
  reg  [`BWFA_CPU_W-1:0] cand;
  wire [NUM_CPU-1:0]     usable;
  wire [SW-1:0]          sticky;
  wire                   fan_any;
  wire                   breach_any;
  wire                   psu_any;
  wire [NUM_CPU-1:0]     sel_onehot;
  wire [NUM_CPU-1:0]     en_d;
  wire                   lastbad_d;
  wire                   done_d;
  genvar                 g;
  integer                i;

  assign fan_any    = |fan_fail;
  assign breach_any = cover_open | bay_door_open;
  assign psu_any    = |(psu_fault & psu_present);
  assign usable     = cpu_installed & ~bad_q;

  // search the next usable processor after the current one
  always @* begin
    next_idx = cur_q;
    next_ok  = 1'b0;
    cand     = cur_q;
    for (i = 1; i <= NUM_CPU; i = i + 1) begin
      cand = cur_q + i[`BWFA_CPU_W-1:0];
      if (!next_ok && usable[cand]) begin
        next_idx = cand;
        next_ok  = 1'b1;
      end
    end
  end

  // watchdog and hand-over
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    cur_d   = cur_q;
    last_d  = last_q;
    bad_d   = bad_q;
    case (state_q)
      ST_SELFTEST: begin
        if (!usable[cur_q] || processor_self_test_fail[cur_q]) begin
          if (cpu_installed[cur_q]) begin
            bad_d[cur_q] = 1'b1;
            last_d       = cur_q;
          end
          if (next_ok && next_idx != cur_q) begin
            cur_d = next_idx;
          end else begin
            state_d = ST_LASTBAD;
            cur_d   = cpu_installed[cur_q] ? cur_q : last_q;
          end
        end else begin
          state_d = ST_COUNT;
          cnt_d   = TIMEOUT_CYC[`BWFA_CNT_W-1:0];
        end
      end
      ST_COUNT: begin
        if (wdog_disable) begin
          state_d = ST_DONE;
        end else if (cnt_q == {`BWFA_CNT_W{1'b0}}) begin
          bad_d[cur_q] = 1'b1;
          last_d       = cur_q;
          state_d      = ST_SELFTEST;
        end else begin
          cnt_d = cnt_q - {{(`BWFA_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      ST_DONE: begin
        state_d = ST_DONE;
      end
      ST_LASTBAD: begin
        cur_d   = last_q;
        state_d = ST_LASTBAD;
      end
      default: begin
        state_d = ST_SELFTEST;
      end
    endcase
  end

  // decoded next state
  assign lastbad_d  = (state_d == ST_LASTBAD);
  assign done_d     = (state_d == ST_DONE) || lastbad_d;
  assign sel_onehot = {{(NUM_CPU-1){1'b0}}, 1'b1} << cur_d;

  // per-processor enable for the next cycle
  generate
    for (g = 0; g < NUM_CPU; g = g + 1) begin : g_en
      assign en_d[g] = lastbad_d ? sel_onehot[g] : (cpu_installed[g] & ~bad_d[g]);
    end
  endgenerate

  // watchdog state
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_SELFTEST;
    end else begin
      state_q <= state_d;
    end
  end

  // watchdog counter
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= {`BWFA_CNT_W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // acting processor index
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_q <= {`BWFA_CPU_W{1'b0}};
    end else begin
      cur_q <= cur_d;
    end
  end

  // processor marked faulty last
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_q <= {`BWFA_CPU_W{1'b0}};
    end else begin
      last_q <= last_d;
    end
  end

  // fault marks
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bad_q <= {NUM_CPU{1'b0}};
    end else begin
      bad_q <= bad_d;
    end
  end

  // fan alert output
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fan_alert <= 1'b0;
    end else begin
      fan_alert <= fan_any;
    end
  end

  // breach alert output
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      breach_alert <= 1'b0;
    end else begin
      breach_alert <= breach_any;
    end
  end

  // supply fault lamp
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      psu_fault_led <= 1'b0;
    end else begin
      psu_fault_led <= psu_any;
    end
  end

  // acting boot processor
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_processor_role <= {`BWFA_CPU_W{1'b0}};
    end else begin
      boot_processor_role <= cur_d;
    end
  end

  // processor enables
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_enable <= {NUM_CPU{1'b0}};
    end else begin
      cpu_enable <= en_d;
    end
  end

  // boot finished flag
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_resilient_boot_done <= 1'b0;
    end else begin
      fault_resilient_boot_done <= done_d;
    end
  end

  // fallback mode flag
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      all_cpu_faulty <= 1'b0;
    end else begin
      all_cpu_faulty <= lastbad_d;
    end
  end

  // visible watchdog count
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdog_count <= {`BWFA_CNT_W{1'b0}};
    end else begin
      wdog_count <= cnt_d;
    end
  end

  // sticky status store
  bwfa_status_bits #(
    .WIDTH (SW)
  ) u_status (
    .clk    (clk),
    .rst_b  (rst_b),
    .set_i  ({bad_q, psu_present, psu_fault & psu_present,
              breach_any, fan_any}),
    .bits_o (sticky)
  );

  assign fan_alert_status    = sticky[0];
  assign breach_alert_status = sticky[1];
  assign psu_fault_status    = sticky[2 +: NUM_PSU];
  assign psu_present_status  = sticky[2 + NUM_PSU +: NUM_PSU];
  assign cpu_fault_status    = sticky[2 + 2 * NUM_PSU +: NUM_CPU];

endmodule

`default_nettype wire

/* test/bwfa_monitor.sv */
// assertions on the ports of bwfa_top
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module bwfa_monitor #(
  parameter [37:0] TIMEOUT_CYC = 38'd20
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [3:0]  fan_fail,
  input wire logic        cover_open,
  input wire logic        bay_door_open,
  input wire logic [2:0]  psu_fault,
  input wire logic [2:0]  psu_present,
  input wire logic [3:0]  cpu_installed,
  input wire logic        fan_alert,
  input wire logic        breach_alert,
  input wire logic        psu_fault_led,
  input wire logic [2:0]  psu_fault_status,
  input wire logic        fan_alert_status,
  input wire logic        breach_alert_status,
  input wire logic [1:0]  boot_processor_role,
  input wire logic [3:0]  cpu_enable,
  input wire logic [3:0]  cpu_fault_status,
  input wire logic        fault_resilient_boot_done,
  input wire logic        all_cpu_faulty,
  input wire logic [37:0] wdog_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_fan_or: assert property (|fan_fail |=> fan_alert && fan_alert_status)
    else $error("fan alert missed");
  a_fan_clear: assert property (fan_fail == 4'h0 |=> !fan_alert)
    else $error("fan alert without cause");
  a_breach_set: assert property (cover_open || bay_door_open |=> breach_alert && breach_alert_status)
    else $error("breach alert missed");
  a_psu_led: assert property (1'b1 |=> psu_fault_led == |$past(psu_fault & psu_present))
    else $error("supply lamp wrong");
  a_psu_sticky: assert property (1'b1 |=> ($past(psu_fault & psu_present) & ~psu_fault_status) == 3'h0)
    else $error("supply fault bit not held");
  a_fault_keep: assert property ((~cpu_fault_status & $past(cpu_fault_status)) == 4'h0)
    else $error("fault mark cleared");
  a_done_hold: assert property (fault_resilient_boot_done |=> fault_resilient_boot_done)
    else $error("boot done dropped");
  a_count_bound: assert property (wdog_count <= TIMEOUT_CYC)
    else $error("watchdog count above timeout");
  a_enable_good: assert property (!all_cpu_faulty && $stable(cpu_fault_status)
    |-> (cpu_enable & (cpu_fault_status | ~cpu_installed)) == 4'h0)
    else $error("faulty processor enabled");
  a_all_faulty: assert property (all_cpu_faulty
    |-> $onehot(cpu_enable) && cpu_enable[boot_processor_role])
    else $error("fallback enable wrong");
endmodule
bind bwfa_top bwfa_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_bwfa_monitor (.*);
`default_nettype wire

/* test/bwfa_cpu_model.sv */
// boot processor firmware model: self test result and watchdog stop
// assumes role changes mark a new acting processor
`timescale 1ns/1ns
`default_nettype none
module bwfa_cpu_model (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [1:0]  role,
  input wire logic [3:0]  fail_mask,
  input wire logic [3:0]  hang_mask,
  input wire logic [3:0]  dly,
  output logic     [3:0]  st_fail,
  output logic            wdog_disable
);
  int         cnt;
  logic [1:0] last;
  assign st_fail = fail_mask;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      last <= 2'h0;
      wdog_disable <= 1'b0;
    end else begin
      last <= role;
      cnt <= (role != last) ? 0 : cnt + 1;
      wdog_disable <= (cnt == dly) && !hang_mask[role];
    end
  end
endmodule
`default_nettype wire

/* test/test_bwfa_top.sv */
// self-checking bench for bwfa_top with a processor model
// assumes a short watchdog timeout parameter
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", nm, e, a); end end
module test_bwfa_top;
  localparam [37:0] TO = 38'd20;
  logic clk = 0, rst_b = 0, cover_open = 0, bay_door_open = 0, k = 0;
  logic [3:0] fan_fail = 0, cpu_installed = 4'hf, fail_m = 0, hang_m = 4'hf, dly = 4'h3;
  logic [2:0] psu_fault = 0, psu_present = 0, ps = 0, pp = 0;
  logic [3:0] bad, en;
  logic [11:0] pf;
  logic fs = 0, bs = 0;
  logic [15:0] tbl [5] = '{16'hf003, 16'hf12c, 16'hff03, 16'ha023, 16'h5413};
  wire [2:0] psu_fault_status, psu_present_status;
  wire [3:0] cpu_enable, cpu_fault_status, processor_self_test_fail;
  wire [1:0] boot_processor_role;
  wire [37:0] wdog_count;
  wire fan_alert, breach_alert, psu_fault_led, fan_alert_status, breach_alert_status;
  wire fault_resilient_boot_done, all_cpu_faulty, wdog_disable;
  int fails = 0, n_compared = 0, seed = 32'h54f5, i, n, r, last;
  bwfa_top #(.TIMEOUT_CYC(TO)) u_bwfa_top (.*);
  bwfa_cpu_model u_bwfa_cpu_model (.clk(clk), .rst_b(rst_b), .role(boot_processor_role),
    .fail_mask(fail_m), .hang_mask(hang_m), .dly(dly), .st_fail(processor_self_test_fail),
    .wdog_disable(wdog_disable));
  initial forever #4 clk = ~clk;
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_b = 1;
    for (n = 0; n < 20 && wdog_count === 38'h0; n++) begin @(posedge clk); #1; end
    `CHK("load", TO, wdog_count)
    @(posedge clk); #1 `CHK("step", TO - 38'd1, wdog_count)
    repeat (150) begin
      @(posedge clk); #1;
      if (k) begin
        `CHK("fan", |pf[3:0], fan_alert)
        `CHK("breach", pf[4] | pf[5], breach_alert)
        `CHK("led", |(pf[8:6] & pf[11:9]), psu_fault_led)
        `CHK("sticky", {fs, bs, ps, pp}, {fan_alert_status, breach_alert_status,
          psu_fault_status, psu_present_status})
      end
      pf = 12'($random(seed));
      k = 1;
      {psu_present, psu_fault, bay_door_open, cover_open, fan_fail} = pf;
      fs |= |pf[3:0];
      bs |= pf[4] | pf[5];
      ps |= pf[8:6] & pf[11:9];
      pp |= pf[11:9];
    end
    for (i = 0; i < 5; i++) begin
      rst_b = 0;
      {cpu_installed, fail_m, hang_m, dly} = tbl[i];
      repeat (10) @(posedge clk);
      #1 rst_b = 1;
      bad = 0;
      r = -1;
      last = 0;
      for (int c = 0; c < 4; c++) if (cpu_installed[c] && r < 0) begin
        if (fail_m[c] | hang_m[c]) begin bad[c] = 1; last = c; end else r = c;
      end
      en = (r < 0) ? 4'h1 << last : cpu_installed & ~bad;
      if (r < 0) r = last;
      for (n = 0; n < 400 && fault_resilient_boot_done !== 1'b1; n++) begin
        @(posedge clk); #1;
      end
      if (n == 400) begin fails++; summarize; end
      @(posedge clk); #1;
      `CHK("role", 2'(r), boot_processor_role)
      `CHK("faults", bad, cpu_fault_status)
      `CHK("all", en == (4'h1 << last) && bad == cpu_installed, all_cpu_faulty)
      `CHK("enable", en, cpu_enable)
    end
    summarize;
  end
endmodule
`default_nettype wire
